// ===== design/timer_channel_pkg.sv
// constants, carriers and helper functions for the timer channel
package timer_channel_pkg;

    localparam logic [7:0] CTRL_OFFSET = 8'h64;
    localparam logic [7:0] FUNC_OFFSET = 8'h65;
    localparam logic [7:0] IER_OFFSET = 8'h66;
    localparam logic [7:0] STATUS_OFFSET = 8'h67;
    localparam logic [7:0] CNT_HI_OFFSET = 8'h68;
    localparam logic [7:0] CNT_LO_OFFSET = 8'h69;
    localparam logic [7:0] GRA_HI_OFFSET = 8'h6A;
    localparam logic [7:0] GRA_LO_OFFSET = 8'h6B;
    localparam logic [7:0] GRB_HI_OFFSET = 8'h6C;
    localparam logic [7:0] GRB_LO_OFFSET = 8'h6D;

    // reserved bits read as one; reset values equal these masks
    localparam logic [7:0] CTRL_RESERVED = 8'h80;
    localparam logic [7:0] FUNC_RESERVED = 8'h88;
    localparam logic [7:0] IER_RESERVED = 8'hF8;
    localparam logic [7:0] STATUS_RESERVED = 8'hF8;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    localparam int FUNC_A_LSB = 0;
    localparam int FUNC_B_LSB = 4;
    localparam int FLAG_A = 0;
    localparam int FLAG_B = 1;
    localparam int FLAG_WRAP = 2;
    localparam int FLAG_W = 3;
    localparam int PRESCALE_W = 3;

    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_STEP = 16'h0001;

    localparam logic [1:0] CLR_NONE = 2'b00;
    localparam logic [1:0] CLR_ON_A = 2'b01;
    localparam logic [1:0] CLR_ON_B = 2'b10;
    localparam logic [1:0] CLR_SYNC = 2'b11;
    localparam logic [1:0] EDGE_RISE = 2'b00;
    localparam logic [1:0] EDGE_FALL = 2'b01;
    localparam logic [1:0] OC_HOLD = 2'b00;
    localparam logic [1:0] OC_LOW = 2'b01;
    localparam logic [1:0] OC_HIGH = 2'b10;
    localparam logic [1:0] IC_RISE = 2'b00;
    localparam logic [1:0] IC_FALL = 2'b01;

    typedef struct packed {
        logic rsvd;
        logic [1:0] clear_sel;
        logic [1:0] edge_sel;
        logic [2:0] clk_sel;
    } chan_ctrl_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    // capture trigger: codes 10 and 11 both take either edge
    function automatic logic cap_hit(input logic [1:0] code, input logic rise, input logic fall);
        if (code == IC_RISE) begin
            return rise;
        end else if (code == IC_FALL) begin
            return fall;
        end
        return rise | fall;
    endfunction

    // pin level after a compare match
    function automatic logic oc_level(input logic [1:0] code, input logic cur);
        case (code)
            OC_HOLD: return cur;
            OC_LOW: return 1'b0;
            OC_HIGH: return 1'b1;
            default: return ~cur;
        endcase
    endfunction

endpackage

// ===== design/clock_prescaler.sv
// free-running divider giving /1, /2, /4 and /8 count enables
`timescale 1ns/1ps
module clock_prescaler
    import timer_channel_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic arst_n, // async reset, active low
    output logic [3:0] tick_div // one-cycle enables /1 /2 /4 /8
);
    logic [PRESCALE_W-1:0] div_reg;
    logic [PRESCALE_W-1:0] div_next;

    assign div_next = div_reg + 3'b001;
    assign tick_div[0] = 1'b1;
    assign tick_div[1] = div_reg[0];
    assign tick_div[2] = &div_reg[1:0];
    assign tick_div[3] = &div_reg;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    property p_div8_gap;
        @(posedge clk_sys) disable iff (!arst_n) tick_div[3] |=> (!tick_div[3]) [*7];
    endproperty
    a_div8_gap: assert property (p_div8_gap) else $error("divide-by-8 enable came early");
endmodule

// ===== design/edge_detect.sv
// rising and falling edge finder for a group of synchronous inputs
`timescale 1ns/1ps
module edge_detect #(
    parameter int WIDTH = 6
) (
    input wire logic clk_sys, // system clock
    input wire logic arst_n, // async reset, active low
    input wire logic [WIDTH-1:0] sig, // sampled inputs
    output logic [WIDTH-1:0] rise, // low-to-high seen this cycle
    output logic [WIDTH-1:0] fall // high-to-low seen this cycle
);
    logic [WIDTH-1:0] prev_reg;

    assign rise = sig & ~prev_reg;
    assign fall = ~sig & prev_reg;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= sig;
        end
    end
endmodule

// ===== design/timer_channel_control.sv
// one 16-bit timer channel: clocking, clearing, compare/capture, flags and interrupts
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module timer_channel_control
    import timer_channel_pkg::*;
(
    input wire logic clk_sys, // system clock, 25 MHz
    input wire logic arst_n, // async reset, active low
    input wire reg_req_s bus_req, // register address, data and strobes
    output logic [7:0] rdata, // read data, cycle after read strobe
    input wire logic [3:0] ext_clock_in, // external clocks a..d
    input wire logic sync_clear_in, // clear pulse from synchronized timers
    input wire logic pin_a_in, // capture/compare pin a, input side
    input wire logic pin_b_in, // capture/compare pin b, input side
    output logic pin_a_out, // pin a level driven
    output logic pin_a_oe, // pin a driven while compare mode
    output logic pin_b_out, // pin b level driven
    output logic pin_b_oe, // pin b driven while compare mode
    output logic reg_a_event_irq, // register a request, gated
    output logic reg_b_event_irq, // register b request, gated
    output logic wrap_irq, // wrap request, gated
    output logic irq // any enabled request
);
    logic [3:0] tick_div;
    logic [5:0] edge_in;
    logic [5:0] edge_rise;
    logic [5:0] edge_fall;

    chan_ctrl_s ctrl_reg;
    logic [7:0] func_reg;
    logic [7:0] ier_reg;
    logic [FLAG_W-1:0] flags_reg;
    logic [FLAG_W-1:0] flags_next;
    logic [FLAG_W-1:0] armed_reg;
    logic [FLAG_W-1:0] armed_next;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [15:0] gra_reg;
    logic [15:0] gra_next;
    logic [15:0] grb_reg;
    logic [15:0] grb_next;
    logic pin_a_reg;
    logic pin_b_reg;
    logic oe_a_reg;
    logic oe_b_reg;
    logic [7:0] rdata_reg;
    logic irq_a_reg;
    logic irq_b_reg;
    logic irq_wrap_reg;
    logic irq_reg;

    clock_prescaler u_prescaler (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .tick_div(tick_div)
    );

    assign edge_in = {pin_b_in, pin_a_in, ext_clock_in};

    edge_detect #(.WIDTH(6)) u_edges (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .sig(edge_in),
        .rise(edge_rise),
        .fall(edge_fall)
    );

    // register decode
    wire wr_ctrl = bus_req.wr && bus_req.addr == CTRL_OFFSET;
    wire wr_func = bus_req.wr && bus_req.addr == FUNC_OFFSET;
    wire wr_ier = bus_req.wr && bus_req.addr == IER_OFFSET;
    wire wr_status = bus_req.wr && bus_req.addr == STATUS_OFFSET;
    wire rd_status = bus_req.rd && bus_req.addr == STATUS_OFFSET;
    wire wr_cnt_hi = bus_req.wr && bus_req.addr == CNT_HI_OFFSET;
    wire wr_cnt_lo = bus_req.wr && bus_req.addr == CNT_LO_OFFSET;
    wire wr_gra_hi = bus_req.wr && bus_req.addr == GRA_HI_OFFSET;
    wire wr_gra_lo = bus_req.wr && bus_req.addr == GRA_LO_OFFSET;
    wire wr_grb_hi = bus_req.wr && bus_req.addr == GRB_HI_OFFSET;
    wire wr_grb_lo = bus_req.wr && bus_req.addr == GRB_LO_OFFSET;
    wire cnt_wr = wr_cnt_hi || wr_cnt_lo;

    // count source selection
    wire [1:0] src_idx = ctrl_reg.clk_sel[1:0];
    wire int_tick = tick_div[src_idx];
    wire ext_rise = edge_rise[src_idx];
    wire ext_fall = edge_fall[src_idx];
    wire ext_tick = ctrl_reg.edge_sel[1] ? (ext_rise | ext_fall) :
                    (ctrl_reg.edge_sel == EDGE_FALL) ? ext_fall : ext_rise;
    wire tick = ctrl_reg.clk_sel[2] ? ext_tick : int_tick;

    // register functions
    wire [2:0] func_a = func_reg[FUNC_A_LSB +: 3];
    wire [2:0] func_b = func_reg[FUNC_B_LSB +: 3];
    wire match_a = !func_a[2] && tick && cnt_reg == gra_reg;
    wire match_b = !func_b[2] && tick && cnt_reg == grb_reg;
    wire cap_a = func_a[2] && cap_hit(func_a[1:0], edge_rise[4], edge_fall[4]);
    wire cap_b = func_b[2] && cap_hit(func_b[1:0], edge_rise[5], edge_fall[5]);
    wire event_a = match_a || cap_a;
    wire event_b = match_b || cap_b;

    // counter clear sources
    wire clear_now = (ctrl_reg.clear_sel == CLR_ON_A && event_a) ||
                     (ctrl_reg.clear_sel == CLR_ON_B && event_b) ||
                     (ctrl_reg.clear_sel == CLR_SYNC && sync_clear_in);
    wire wrap_evt = tick && cnt_reg == COUNT_MAX && !clear_now && !cnt_wr;

    // clear beats a software write, which beats counting
    always_comb begin
        cnt_next = cnt_reg;
        if (clear_now) begin
            cnt_next = COUNT_ZERO;
        end else if (wr_cnt_hi) begin
            cnt_next = {bus_req.wdata, cnt_reg[7:0]};
        end else if (wr_cnt_lo) begin
            cnt_next = {cnt_reg[15:8], bus_req.wdata};
        end else if (tick) begin
            cnt_next = cnt_reg + COUNT_STEP;
        end
    end

    // capture beats a software write
    always_comb begin
        gra_next = gra_reg;
        grb_next = grb_reg;
        if (cap_a) begin
            gra_next = cnt_reg;
        end else if (wr_gra_hi) begin
            gra_next = {bus_req.wdata, gra_reg[7:0]};
        end else if (wr_gra_lo) begin
            gra_next = {gra_reg[15:8], bus_req.wdata};
        end
        if (cap_b) begin
            grb_next = cnt_reg;
        end else if (wr_grb_hi) begin
            grb_next = {bus_req.wdata, grb_reg[7:0]};
        end else if (wr_grb_lo) begin
            grb_next = {grb_reg[15:8], bus_req.wdata};
        end
    end

    // a flag clears only by writing 0 after reading it as 1; a new event wins
    wire [FLAG_W-1:0] set_mask = {wrap_evt, event_b, event_a};
    wire [FLAG_W-1:0] clr_mask = wr_status ? (armed_reg & ~bus_req.wdata[FLAG_W-1:0]) : '0;
    assign flags_next = (flags_reg & ~clr_mask) | set_mask;
    assign armed_next = (armed_reg | (rd_status ? flags_reg : '0)) & flags_next & ~clr_mask;
    wire [FLAG_W-1:0] gated = flags_next & ier_reg[FLAG_W-1:0];

    // read mux; reserved bits held at one in ctrl, func and ier, ORed in here for status
    wire [7:0] read_mux =
        (bus_req.addr == CTRL_OFFSET) ? ctrl_reg :
        (bus_req.addr == FUNC_OFFSET) ? func_reg :
        (bus_req.addr == IER_OFFSET) ? ier_reg :
        (bus_req.addr == STATUS_OFFSET) ? (STATUS_RESERVED | {5'b00000, flags_reg}) :
        (bus_req.addr == CNT_HI_OFFSET) ? cnt_reg[15:8] :
        (bus_req.addr == CNT_LO_OFFSET) ? cnt_reg[7:0] :
        (bus_req.addr == GRA_HI_OFFSET) ? gra_reg[15:8] :
        (bus_req.addr == GRA_LO_OFFSET) ? gra_reg[7:0] :
        (bus_req.addr == GRB_HI_OFFSET) ? grb_reg[15:8] :
        (bus_req.addr == GRB_LO_OFFSET) ? grb_reg[7:0] : UNMAPPED_READ;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= CTRL_RESERVED;
            func_reg <= FUNC_RESERVED;
            ier_reg <= IER_RESERVED;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= bus_req.wdata | CTRL_RESERVED;
            end
            if (wr_func) begin
                func_reg <= bus_req.wdata | FUNC_RESERVED;
            end
            if (wr_ier) begin
                ier_reg <= bus_req.wdata | IER_RESERVED;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= COUNT_ZERO;
            gra_reg <= COUNT_MAX;
            grb_reg <= COUNT_MAX;
            flags_reg <= '0;
            armed_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
            gra_reg <= gra_next;
            grb_reg <= grb_next;
            flags_reg <= flags_next;
            armed_reg <= armed_next;
        end
    end

    // pins: driven only while the register is in compare mode
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_a_reg <= 1'b0;
            pin_b_reg <= 1'b0;
            oe_a_reg <= 1'b0;
            oe_b_reg <= 1'b0;
        end else begin
            if (match_a) begin
                pin_a_reg <= oc_level(func_a[1:0], pin_a_reg);
            end
            if (match_b) begin
                pin_b_reg <= oc_level(func_b[1:0], pin_b_reg);
            end
            oe_a_reg <= !func_a[2];
            oe_b_reg <= !func_b[2];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= UNMAPPED_READ;
            irq_a_reg <= 1'b0;
            irq_b_reg <= 1'b0;
            irq_wrap_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            rdata_reg <= bus_req.rd ? read_mux : UNMAPPED_READ;
            irq_a_reg <= gated[FLAG_A];
            irq_b_reg <= gated[FLAG_B];
            irq_wrap_reg <= gated[FLAG_WRAP];
            irq_reg <= |gated;
        end
    end

    assign rdata = rdata_reg;
    assign pin_a_out = pin_a_reg;
    assign pin_b_out = pin_b_reg;
    assign pin_a_oe = oe_a_reg;
    assign pin_b_oe = oe_b_reg;
    assign reg_a_event_irq = irq_a_reg;
    assign reg_b_event_irq = irq_b_reg;
    assign wrap_irq = irq_wrap_reg;
    assign irq = irq_reg;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    wire quiet = !clear_now && !cnt_wr;

    property p_div1_count;
        (ctrl_reg.clk_sel == 3'b000 && quiet) |=> cnt_reg == 16'($past(cnt_reg) + 16'h0001);
    endproperty
    a_div1_count: assert property (p_div1_count) else $error("divide-by-1 count missed");

    property p_div2_hold;
        (ctrl_reg.clk_sel == 3'b001 && !tick_div[1] && quiet) |=> cnt_reg == $past(cnt_reg);
    endproperty
    a_div2_hold: assert property (p_div2_hold) else $error("divide-by-2 counted off enable");

    property p_ext_rise;
        (ctrl_reg.clk_sel == 3'b101 && ctrl_reg.edge_sel == 2'b00 && edge_rise[1] && quiet)
            |=> cnt_reg == 16'($past(cnt_reg) + 16'h0001);
    endproperty
    a_ext_rise: assert property (p_ext_rise) else $error("external rising edge not counted");

    property p_ext_fall_only;
        (ctrl_reg.clk_sel[2] && ctrl_reg.edge_sel == 2'b01 && !ext_fall && quiet)
            |=> cnt_reg == $past(cnt_reg);
    endproperty
    a_ext_fall_only: assert property (p_ext_fall_only) else $error("counted without falling edge");

    property p_clear_a;
        (ctrl_reg.clear_sel == 2'b01 && event_a) |=> cnt_reg == 16'h0000;
    endproperty
    a_clear_a: assert property (p_clear_a) else $error("register a event did not clear");

    property p_clear_none;
        (ctrl_reg.clear_sel == 2'b00 && !sync_clear_in && !cnt_wr && tick && cnt_reg != 16'hFFFF)
            |=> cnt_reg != 16'h0000;
    endproperty
    a_clear_none: assert property (p_clear_none) else $error("counter cleared with no source");

    property p_sync_clear;
        (ctrl_reg.clear_sel == 2'b11 && sync_clear_in) |=> cnt_reg == 16'h0000;
    endproperty
    a_sync_clear: assert property (p_sync_clear) else $error("synchronous clear missed");

    property p_toggle_a;
        (match_a && func_a == 3'b011) |=> pin_a_out != $past(pin_a_out);
    endproperty
    a_toggle_a: assert property (p_toggle_a) else $error("pin a did not toggle");

    property p_high_b;
        (match_b && func_b == 3'b010) |=> pin_b_out && pin_b_oe ##1 pin_b_out || $past(match_b);
    endproperty
    a_high_b: assert property (p_high_b) else $error("pin b not driven high");

    property p_capture_a;
        (func_a == 3'b100 && edge_rise[4]) |=> gra_reg == $past(cnt_reg) && flags_reg[0];
    endproperty
    a_capture_a: assert property (p_capture_a) else $error("register a capture missed");

    property p_capture_b;
        (func_b == 3'b101 && edge_fall[5]) |=> grb_reg == $past(cnt_reg) && flags_reg[1];
    endproperty
    a_capture_b: assert property (p_capture_b) else $error("register b capture missed");

    property p_gate_wrap;
        !ier_reg[2] |=> !wrap_irq;
    endproperty
    a_gate_wrap: assert property (p_gate_wrap) else $error("wrap request passed while disabled");

    property p_wrap_set;
        wrap_evt |=> flags_reg[2] && cnt_reg == 16'h0000 ##1 flags_reg[2] || $past(wr_status);
    endproperty
    a_wrap_set: assert property (p_wrap_set) else $error("wrap flag not set");

    sequence s_read_set;
        rd_status && flags_reg[2] && !wr_status;
    endsequence
    sequence s_write_zero;
        wr_status && !bus_req.wdata[2] && !wrap_evt;
    endsequence
    property p_wrap_clear;
        s_read_set ##1 !wr_status ##1 s_write_zero |=> !flags_reg[2];
    endproperty
    a_wrap_clear: assert property (p_wrap_clear) else $error("wrap flag not cleared");

    property p_no_blind_clear;
        (wr_status && !armed_reg[2] && flags_reg[2]) |=> flags_reg[2];
    endproperty
    a_no_blind_clear: assert property (p_no_blind_clear) else $error("flag cleared without read");

    property p_both_111;
        (func_a == 3'b111 && edge_fall[4]) |-> cap_a;
    endproperty
    a_both_111: assert property (p_both_111) else $error("code 111 missed falling edge");

    property p_reserved_read;
        (bus_req.rd && bus_req.addr == 8'h66) |=> rdata[7:3] == 5'b11111;
    endproperty
    a_reserved_read: assert property (p_reserved_read) else $error("reserved bits not one");
endmodule

// ===== tb/timer_far_side.sv
// far-side model: external clock lines, capture pins and synchronized clear pulse
`timescale 1ns/1ps
module timer_far_side (
    input wire logic clk_sys, // system clock
    output logic [3:0] ext_clock_in, // external clocks a..d
    output logic pin_a_in, // capture pin a
    output logic pin_b_in, // capture pin b
    output logic sync_clear_in // clear pulse from other timers
);
    initial begin
        ext_clock_in = 4'h0;
        pin_a_in = 1'b0;
        pin_b_in = 1'b0;
        sync_clear_in = 1'b0;
    end
    // whole pulses only, each level held gap+1 cycles; the line rests low between bursts
    task automatic clk_pulses(input int idx, input int n, input int gap);
        for (int i = 0; i < 2 * n; i++) begin
            @(posedge clk_sys);
            ext_clock_in[idx] <= ~ext_clock_in[idx];
            repeat (gap) @(posedge clk_sys);
        end
    endtask
    task automatic set_pin(input int idx, input logic lvl);
        @(posedge clk_sys);
        if (idx == 0) begin
            pin_a_in <= lvl;
        end else begin
            pin_b_in <= lvl;
        end
    endtask
    task automatic sync_pulse();
        @(posedge clk_sys);
        sync_clear_in <= 1'b1;
        @(posedge clk_sys);
        sync_clear_in <= 1'b0;
    endtask
endmodule

// ===== tb/timer_channel_control_tb_top.sv
// self-checking bench for the timer channel
`timescale 1ns/1ps
module timer_channel_control_tb_top;
    import timer_channel_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    reg_req_s bus_req = '0;
    logic [7:0] rdata;
    logic [3:0] ext_clock_in;
    logic sync_clear_in, pin_a_in, pin_b_in;
    logic pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
    logic reg_a_event_irq, reg_b_event_irq, wrap_irq, irq;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    always #20 clk_sys = ~clk_sys;

    timer_channel_control u_timer_channel_control (.clk_sys(clk_sys), .arst_n(arst_n), .bus_req(bus_req),
        .rdata(rdata), .ext_clock_in(ext_clock_in), .sync_clear_in(sync_clear_in), .pin_a_in(pin_a_in),
        .pin_b_in(pin_b_in), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out),
        .pin_b_oe(pin_b_oe), .reg_a_event_irq(reg_a_event_irq), .reg_b_event_irq(reg_b_event_irq),
        .wrap_irq(wrap_irq), .irq(irq));
    timer_far_side u_timer_far_side (.clk_sys(clk_sys), .ext_clock_in(ext_clock_in), .pin_a_in(pin_a_in),
        .pin_b_in(pin_b_in), .sync_clear_in(sync_clear_in));

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bw(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe, so it is taken mid-cycle
    task automatic br(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        @(negedge clk_sys);
        d = rdata;
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        br(a, v);
        chk(nm, exp, v);
    endtask
    // low byte first so the counter cannot sweep through a compare value meanwhile
    task automatic w16(input logic [7:0] off, input logic [15:0] v);
        bw(off + 8'h01, v[7:0]);
        bw(off, v[15:8]);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic t_regs();
        rc("ctrl reset", CTRL_OFFSET, 8'h80);
        rc("func reset", FUNC_OFFSET, 8'h88);
        rc("ier reset", IER_OFFSET, 8'hF8);
        rc("status reset", STATUS_OFFSET, 8'hF8);
        bw(FUNC_OFFSET, 8'h77);
        rc("func reserved", FUNC_OFFSET, 8'hFF);
        bw(8'h70, 8'h55);
        rc("unmapped", 8'h70, 8'h00);
        $display("test regs done");
    endtask
    // 16 cycles apart both reads sit at the same divider phase
    task automatic t_presc();
        logic [7:0] v0, v1;
        for (int s = 0; s < 4; s++) begin
            bw(CTRL_OFFSET, 8'(8'h80 + s));
            br(CNT_LO_OFFSET, v0);
            repeat (14) @(posedge clk_sys);
            br(CNT_LO_OFFSET, v1);
            chk("prescale count", 8'(16 >> s), v1 - v0);
        end
        $display("test prescale done");
    endtask
    task automatic t_ext();
        logic [7:0] v0, v1;
        for (int i = 0; i < 4; i++) begin
            for (int e = 0; e < 4; e++) begin
                bw(CTRL_OFFSET, 8'(8'h84 + i + 8 * e));
                br(CNT_LO_OFFSET, v0);
                u_timer_far_side.clk_pulses(i, 3, 1 + 3 * (i % 2));
                wt(3);
                br(CNT_LO_OFFSET, v1);
                chk("ext count", (e > 1) ? 8'h06 : 8'h03, v1 - v0);
            end
        end
        $display("test external clock done");
    endtask
    task automatic t_cmp();
        logic [2:0] code [4] = '{3'd2, 3'd0, 3'd1, 3'd3};
        bw(CTRL_OFFSET, 8'h80);
        for (int r = 0; r < 2; r++) begin
            for (int k = 0; k < 4; k++) begin
                bw(FUNC_OFFSET, 8'(8'h88 + (code[k] << (4 * r))));
                w16(GRA_HI_OFFSET + 8'(2 * r), 16'h0010);
                w16(CNT_HI_OFFSET, 16'h0000);
                wt(24);
                chk("compare pin", 8'(k != 2), 8'(r ? pin_b_out : pin_a_out));
                chk("compare oe", 8'h01, 8'(r ? pin_b_oe : pin_a_oe));
            end
            bw(IER_OFFSET, 8'(8'hF9 + r));
            wt(2);
            chk("event irq", 8'h01, 8'(r ? reg_b_event_irq : reg_a_event_irq));
            chk("irq", 8'h01, 8'(irq));
            bw(IER_OFFSET, 8'hF8);
            wt(2);
            chk("irq masked", 8'h00, 8'(irq));
            bw(STATUS_OFFSET, 8'h00);
            rc("flag kept", STATUS_OFFSET, 8'(8'hF9 + 2 * r));
            bw(STATUS_OFFSET, 8'h00);
            rc("flag cleared", STATUS_OFFSET, 8'hF8);
        end
        $display("test compare done");
    endtask
    task automatic t_cap();
        logic [7:0] v;
        for (int r = 0; r < 2; r++) begin
            for (int c = 4; c < 8; c++) begin
                bw(FUNC_OFFSET, 8'(8'h88 + (c << (4 * r))));
                for (int lvl = 1; lvl >= 0; lvl--) begin
                    w16(GRA_HI_OFFSET + 8'(2 * r), 16'h0000);
                    w16(CNT_HI_OFFSET, 16'h4000);
                    u_timer_far_side.set_pin(r, lvl[0]);
                    wt(4);
                    chk("capture oe", 8'h00, 8'(r ? pin_b_oe : pin_a_oe));
                    br(GRA_HI_OFFSET + 8'(2 * r), v);
                    chk("capture hi", (c == 4 + lvl) ? 8'h00 : 8'h40, v);
                end
            end
        end
        $display("test capture done");
    endtask
    // reads two cycles apart cover every phase of a period of 5 or 9
    task automatic t_clr();
        logic [7:0] v, mx;
        bw(FUNC_OFFSET, 8'h88);
        w16(GRA_HI_OFFSET, 16'h0004);
        w16(GRB_HI_OFFSET, 16'h0008);
        for (int r = 0; r < 2; r++) begin
            bw(CTRL_OFFSET, 8'(8'hA0 + 8'h20 * r));
            w16(CNT_HI_OFFSET, 16'h0000);
            mx = 8'h00;
            for (int j = 0; j < 9; j++) begin
                br(CNT_LO_OFFSET, v);
                mx = (v > mx) ? v : mx;
            end
            chk("clear period", 8'(4 + 4 * r), mx);
        end
        for (int r = 0; r < 2; r++) begin
            bw(CTRL_OFFSET, r ? 8'h80 : 8'hE0);
            w16(CNT_HI_OFFSET, 16'h4000);
            u_timer_far_side.sync_pulse();
            rc("sync clear", CNT_HI_OFFSET, r ? 8'h40 : 8'h00);
        end
        $display("test clear done");
    endtask
    task automatic t_wrap();
        logic [7:0] v;
        bw(FUNC_OFFSET, 8'hCC);
        bw(CTRL_OFFSET, 8'h80);
        br(STATUS_OFFSET, v);
        bw(STATUS_OFFSET, 8'h00);
        bw(IER_OFFSET, 8'hFC);
        w16(CNT_HI_OFFSET, 16'hFFF0);
        wt(20);
        chk("wrap irq", 8'h01, 8'(wrap_irq));
        bw(STATUS_OFFSET, 8'h00);
        rc("wrap flag", STATUS_OFFSET, 8'hFC);
        bw(STATUS_OFFSET, 8'h00);
        rc("wrap cleared", STATUS_OFFSET, 8'hF8);
        chk("wrap irq off", 8'h00, 8'(wrap_irq));
        $display("test wrap done");
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_regs();
        t_presc();
        t_ext();
        t_cmp();
        t_cap();
        t_clr();
        t_wrap();
        summarize();
    end
endmodule
